//--- include/lsu_defs.svh
// constants for the load/store unit: offsets, masks, list width, indices, reset values
`ifndef LSU_DEFS_SVH
`define LSU_DEFS_SVH
`define LSU_PC_AHEAD      32'h0000_0004
`define LSU_WORD_BYTES    32'h0000_0004
`define LSU_WORD_MASK     32'hFFFF_FFFC
`define LSU_ADR_MAX       32'h0000_03FC
`define LSU_LIST_W        9
`define LSU_LIST_TOP_BIT  8
`define LSU_RD_SP_IDX     4'hD
`define LSU_RD_LR_IDX     4'hE
`define LSU_GPR_RESET     32'h0000_0000
`define LSU_SP_RESET      32'h0000_0000
`define LSU_LR_RESET      32'h0000_0000
`endif

//--- include/lsu_pkg.sv
// types shared by the load/store unit and its address generator
package lsu_pkg;
   // operations accepted on the command port
   typedef enum logic [3:0] {
      OP_ADR, OP_LD_IMM, OP_ST_IMM, OP_LD_REG, OP_ST_REG,
      OP_LD_LIT, OP_LDM, OP_STM, OP_PUSH, OP_POP
   } lsu_op_e;
   // access width
   typedef enum logic [1:0] {
      SZ_WORD, SZ_HALF, SZ_BYTE
   } lsu_size_e;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE, ST_ACCESS, ST_FINISH
   } lsu_state_e;
endpackage : lsu_pkg

//--- include/lsu_agu_if.sv
// operands to and addresses from the address generator
`timescale 1ns/10ps
interface lsu_agu_if;
   lsu_pkg::lsu_op_e   op;
   lsu_pkg::lsu_size_e size;
   logic               sp_base;
   logic [31:0]        base;
   logic [31:0]        offset;
   logic [31:0]        sp;
   logic [31:0]        pc;
   logic [9:0]         imm;
   logic [3:0]         count;
   logic [31:0]        addr;
   logic [31:0]        wb_value;
   logic               misaligned;
   modport core (output op, size, sp_base, base, offset, sp, pc, imm, count,
                 input addr, wb_value, misaligned);
   modport agu  (input op, size, sp_base, base, offset, sp, pc, imm, count,
                 output addr, wb_value, misaligned);
endinterface : lsu_agu_if

//--- rtl/lsu_agu.sv
// address generator: access address, writeback value and alignment check
`timescale 1ns/10ps
`include "lsu_defs.svh"
module lsu_agu (
   lsu_agu_if.agu  agu   // operands in, addresses out
);
   logic [31:0] pc_view;
   logic [31:0] span;
   logic [31:0] imm_ext;

   // pc as seen by arithmetic, total span of a multiple transfer
   always_comb begin
      pc_view = agu.pc + `LSU_PC_AHEAD;
      span    = {26'h000_0000, agu.count, 2'b00};
      imm_ext = {22'h00_0000, agu.imm};
   end

   // address per operation
   always_comb begin
      agu.wb_value = agu.base;
      case (agu.op)
         lsu_pkg::OP_ADR,
         lsu_pkg::OP_LD_LIT: agu.addr = (pc_view & `LSU_WORD_MASK) + imm_ext;
         lsu_pkg::OP_LD_IMM,
         lsu_pkg::OP_ST_IMM: agu.addr = (agu.sp_base ? agu.sp : agu.base) + imm_ext;
         lsu_pkg::OP_LD_REG,
         lsu_pkg::OP_ST_REG: agu.addr = agu.base + agu.offset;
         lsu_pkg::OP_PUSH: begin
            agu.addr     = agu.sp - span;
            agu.wb_value = agu.sp - span;
         end
         lsu_pkg::OP_POP: begin
            agu.addr     = agu.sp;
            agu.wb_value = agu.sp + span;
         end
         default: begin
            agu.addr     = agu.base;
            agu.wb_value = agu.base + span;
         end
      endcase
   end

   always_comb begin
      if (agu.op == lsu_pkg::OP_ADR) begin
         agu.misaligned = 1'b0;
      end else if ((agu.op < lsu_pkg::OP_LD_LIT) && (agu.size == lsu_pkg::SZ_HALF)) begin
         agu.misaligned = agu.addr[0];
      end else if ((agu.op < lsu_pkg::OP_LD_LIT) && (agu.size == lsu_pkg::SZ_BYTE)) begin
         agu.misaligned = 1'b0;
      end else begin
         agu.misaligned = |agu.addr[1:0];
      end
   end
endmodule : lsu_agu

//--- rtl/lsu_core.sv
// load/store unit: sequencer, low register file, stack pointer and memory port
//
// Overview of operation
// - address generation adds immediate to pc, result to low register
// - pc seen by arithmetic is current instruction address plus four
// - immediate loads zero extend bytes and halfwords to 32 bits
// - stores write whole word, low byte or low halfword
// - immediate address is base or stack pointer plus offset, default zero
// - a misaligned access is not made and raises a hard fault
// - register offset loads give word, zero or sign extended byte and half
// - register offset address is base plus offset register
// - literal load reads an aligned word relative to the pc
// - multiple transfers use consecutive words four bytes apart
// - multiple transfers go in ascending register order
// - writeback sets base to original plus four per register
// - none of these operations changes the condition flags
// - push stores downward ending with stack at lowest address
// - pop loads upward leaving stack above highest read
// - pop into pc branches and bit zero sets the state bit
`timescale 1ns/10ps
`include "lsu_defs.svh"
module lsu_core (
   input  wire logic               i_clk_sys,      // system clock
   input  wire logic               i_srst,         // sync reset, high
   input  wire logic               i_cmd_valid,    // command offered
   input  wire lsu_pkg::lsu_op_e   i_cmd_op,       // operation
   input  wire lsu_pkg::lsu_size_e i_cmd_size,     // single access width
   input  wire logic               i_cmd_sign,     // sign extend load
   input  wire logic               i_cmd_sp_base,  // stack pointer as base
   input  wire logic               i_cmd_wback,    // multiple writeback
   input  wire logic [2:0]         i_cmd_rt,       // transfer_reg index
   input  wire logic [2:0]         i_cmd_rn,       // base_reg index
   input  wire logic [2:0]         i_cmd_rm,       // offset_reg index
   input  wire logic [9:0]         i_cmd_imm,      // byte offset
   input  wire logic [8:0]         i_cmd_list,     // list, bit 8 lr/pc
   input  wire logic [31:0]        i_cmd_pc,       // current instruction addr
   input  wire logic               i_wr_en,        // preload write, idle only
   input  wire logic [3:0]         i_wr_idx,       // 0-7, 13 sp, 14 lr
   input  wire logic [31:0]        i_wr_data,      // preload data
   input  wire logic [3:0]         i_rd_idx,       // read index
   input  wire logic               i_mem_ack,      // memory done
   input  wire logic [31:0]        i_mem_rdata,    // load data, low aligned
   output logic                    o_ready,        // accepts command
   output logic                    o_done,         // command finished
   output logic                    o_fault,        // hard_fault_exception
   output logic                    o_branch,       // pc loaded by pop
   output logic [31:0]             o_branch_addr,  // branch target
   output logic                    o_tbit,         // state bit from target
   output logic                    o_flags_we,     // flag write, never set
   output logic                    o_mem_req,      // memory request
   output logic                    o_mem_we,       // store
   output logic [31:0]             o_mem_addr,     // byte address
   output logic [31:0]             o_mem_wdata,    // store data, low aligned
   output lsu_pkg::lsu_size_e      o_mem_size,     // access width
   output logic [31:0]             o_rd_data       // read port data
);
   lsu_agu_if agu_bus ();

   lsu_pkg::lsu_state_e st, next_st;
   lsu_pkg::lsu_op_e    op, next_op;
   lsu_pkg::lsu_size_e  size, next_size;
   logic        sign, next_sign, wback, next_wback;
   logic [2:0]  rt, next_rt, rn, next_rn;
   logic [8:0]  list, next_list;
   logic [31:0] wb_value, next_wb_value, first_addr, next_first_addr;
   logic [31:0] gpr [0:7];
   logic [31:0] next_gpr [0:7];
   logic [31:0] sp, next_sp, lr, next_lr, pc_load, next_pc_load;
   logic        pc_hit, next_pc_hit, fault_hit, next_fault_hit;
   logic        next_ready, next_done, next_fault, next_branch, next_tbit;
   logic        next_mem_req, next_mem_we;
   logic [31:0] next_branch_addr, next_mem_addr, next_mem_wdata, next_rd_data;
   lsu_pkg::lsu_size_e next_mem_size;
   logic        is_multi, is_load, last;
   logic [3:0]  cur_idx, new_idx;
   logic [8:0]  rest;

   // number of registers in a list
   function automatic logic [3:0] count_bits(input logic [8:0] l);
      logic [3:0] n;
      n = 4'h0;
      for (int k = 0; k < `LSU_LIST_W; k++) begin
         n = n + {3'b000, l[k]};
      end
      return n;
   endfunction : count_bits

   // lowest listed register, ascending order
   function automatic logic [3:0] lowest(input logic [8:0] l);
      logic [3:0] r;
      r = 4'h0;
      for (int k = `LSU_LIST_TOP_BIT; k >= 0; k--) begin
         if (l[k]) begin
            r = 4'(k);
         end
      end
      return r;
   endfunction : lowest

   // store lane data for a register and width
   function automatic logic [31:0] lane_out(input logic [31:0] v,
                                            input lsu_pkg::lsu_size_e s);
      logic [31:0] r;
      r = v;
      // low byte or low half only
      if (s == lsu_pkg::SZ_BYTE) begin
         r = {24'h00_0000, v[7:0]};
      end else if (s == lsu_pkg::SZ_HALF) begin
         r = {16'h0000, v[15:0]};
      end
      return r;
   endfunction : lane_out

   // load extension to 32 bits
   function automatic logic [31:0] extend(input logic [31:0] d,
                                          input lsu_pkg::lsu_size_e s,
                                          input logic sx);
      logic [31:0] r;
      r = d;
      if (s == lsu_pkg::SZ_BYTE) begin
         r = {{24{sx & d[7]}}, d[7:0]};
      end else if (s == lsu_pkg::SZ_HALF) begin
         r = {{16{sx & d[15]}}, d[15:0]};
      end
      return r;
   endfunction : extend

   // register read by index
   function automatic logic [31:0] reg_read(input logic [3:0] idx,
                                            input logic [31:0] g [0:7],
                                            input logic [31:0] s,
                                            input logic [31:0] l);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (idx < 4'h8) begin
         r = g[idx[2:0]];
      end else if (idx == `LSU_RD_SP_IDX) begin
         r = s;
      end else if (idx == `LSU_RD_LR_IDX) begin
         r = l;
      end
      return r;
   endfunction : reg_read

   // operands to the address generator, taken from the offered command
   always_comb begin
      agu_bus.op      = i_cmd_op;
      agu_bus.size    = i_cmd_size;
      agu_bus.sp_base = i_cmd_sp_base;
      agu_bus.base    = gpr[i_cmd_rn];
      agu_bus.offset  = gpr[i_cmd_rm];
      agu_bus.sp      = sp;
      agu_bus.pc      = i_cmd_pc;
      agu_bus.imm     = i_cmd_imm;
      agu_bus.count   = count_bits(i_cmd_list);
   end

   lsu_agu u_agu (
      .agu (agu_bus.agu)
   );

   // current transfer decode
   always_comb begin
      is_multi = (op == lsu_pkg::OP_LDM) || (op == lsu_pkg::OP_STM) ||
                 (op == lsu_pkg::OP_PUSH) || (op == lsu_pkg::OP_POP);
      is_load  = (op == lsu_pkg::OP_LD_IMM) || (op == lsu_pkg::OP_LD_REG) ||
                 (op == lsu_pkg::OP_LD_LIT) || (op == lsu_pkg::OP_LDM) ||
                 (op == lsu_pkg::OP_POP);
      cur_idx  = is_multi ? lowest(list) : {1'b0, rt};
      rest     = list & ~(9'h001 << cur_idx);
      new_idx  = lowest(rest);
      last     = !is_multi || (rest == 9'h000);
   end

   // sequencer next state
   always_comb begin
      next_st = st;  next_op = op;  next_size = size;  next_sign = sign;
      next_wback = wback;  next_rt = rt;  next_rn = rn;  next_list = list;
      next_wb_value = wb_value;  next_first_addr = first_addr;
      next_gpr = gpr;  next_sp = sp;  next_lr = lr;
      next_pc_load = pc_load;  next_pc_hit = pc_hit;  next_fault_hit = fault_hit;
      next_ready = o_ready;  next_done = 1'b0;  next_fault = 1'b0;
      next_branch = 1'b0;  next_branch_addr = o_branch_addr;  next_tbit = o_tbit;
      next_mem_req = o_mem_req;  next_mem_we = o_mem_we;
      next_mem_addr = o_mem_addr;  next_mem_wdata = o_mem_wdata;
      next_mem_size = o_mem_size;
      next_rd_data = reg_read(i_rd_idx, gpr, sp, lr);
      case (st)
         lsu_pkg::ST_IDLE: begin
            next_ready = 1'b1;
            if (i_wr_en && !i_cmd_valid) begin
               if (i_wr_idx < 4'h8) begin
                  next_gpr[i_wr_idx[2:0]] = i_wr_data;
               end else if (i_wr_idx == `LSU_RD_SP_IDX) begin
                  next_sp = i_wr_data;
               end else if (i_wr_idx == `LSU_RD_LR_IDX) begin
                  next_lr = i_wr_data;
               end
            end
            if (i_cmd_valid && o_ready) begin
               next_ready = 1'b0;  next_op = i_cmd_op;  next_rt = i_cmd_rt;
               next_rn = i_cmd_rn;  next_list = i_cmd_list;  next_pc_hit = 1'b0;
               next_sign = i_cmd_sign && (i_cmd_op == lsu_pkg::OP_LD_REG);
               next_wback = i_cmd_wback;
               next_size = i_cmd_size;
               if ((i_cmd_op >= lsu_pkg::OP_LD_LIT) || (i_cmd_op == lsu_pkg::OP_ADR)) begin
                  next_size = lsu_pkg::SZ_WORD;
               end
               next_wb_value   = agu_bus.wb_value;
               next_first_addr = agu_bus.addr;
               next_st = lsu_pkg::ST_FINISH;
               if (agu_bus.misaligned) begin
                  next_fault_hit = 1'b1;
               end else if (i_cmd_op == lsu_pkg::OP_ADR) begin
                  next_gpr[i_cmd_rt] = agu_bus.addr;
               end else begin
                  next_st       = lsu_pkg::ST_ACCESS;
                  next_mem_req  = 1'b1;
                  next_mem_addr = agu_bus.addr;
                  next_mem_size = ((i_cmd_op >= lsu_pkg::OP_LD_LIT) ||
                                   (i_cmd_op == lsu_pkg::OP_ADR)) ?
                                  lsu_pkg::SZ_WORD : i_cmd_size;
                  next_mem_we   = (i_cmd_op == lsu_pkg::OP_ST_IMM) ||
                                  (i_cmd_op == lsu_pkg::OP_ST_REG) ||
                                  (i_cmd_op == lsu_pkg::OP_STM) ||
                                  (i_cmd_op == lsu_pkg::OP_PUSH);
                  // first store is lowest listed register
                  next_mem_wdata = (i_cmd_op >= lsu_pkg::OP_LDM) ?
                                   reg_read(lowest(i_cmd_list), gpr, sp, lr) :
                                   lane_out(gpr[i_cmd_rt], i_cmd_size);
                  if ((i_cmd_op >= lsu_pkg::OP_LDM) && (lowest(i_cmd_list) == 4'h8)) begin
                     next_mem_wdata = lr;
                  end
               end
            end
         end
         lsu_pkg::ST_ACCESS: begin
            if (i_mem_ack) begin
               if (is_load && (cur_idx == 4'h8)) begin
                  next_pc_load = i_mem_rdata;
                  next_pc_hit  = 1'b1;
               end else if (is_load) begin
                  next_gpr[cur_idx[2:0]] = extend(i_mem_rdata, size, sign);
               end
               next_list = rest;
               if (!last) begin
                  next_mem_addr  = o_mem_addr + `LSU_WORD_BYTES;
                  next_mem_wdata = (new_idx == 4'h8) ? lr : gpr[new_idx[2:0]];
               end else begin
                  next_mem_req = 1'b0;
                  next_mem_we  = 1'b0;
                  next_st      = lsu_pkg::ST_FINISH;
                  if (((op == lsu_pkg::OP_LDM) || (op == lsu_pkg::OP_STM)) && wback) begin
                     next_gpr[rn] = wb_value;
                  end
                  if ((op == lsu_pkg::OP_PUSH) || (op == lsu_pkg::OP_POP)) begin
                     next_sp = wb_value;
                  end
               end
            end
         end
         default: begin
            next_done  = 1'b1;
            next_ready = 1'b1;
            next_st    = lsu_pkg::ST_IDLE;
            next_fault = fault_hit;  next_fault_hit = 1'b0;
            if (pc_hit) begin
               next_branch      = 1'b1;
               next_branch_addr = {pc_load[31:1], 1'b0};
               next_tbit        = pc_load[0];
            end
         end
      endcase
   end

   // state registers
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         st <= lsu_pkg::ST_IDLE;  op <= lsu_pkg::OP_ADR;  size <= lsu_pkg::SZ_WORD;
         sign <= 1'b0;  wback <= 1'b0;  rt <= 3'h0;  rn <= 3'h0;  list <= 9'h000;
         wb_value <= 32'h0000_0000;  first_addr <= 32'h0000_0000;
         for (int k = 0; k < 8; k++) begin
            gpr[k] <= `LSU_GPR_RESET;
         end
         sp <= `LSU_SP_RESET;  lr <= `LSU_LR_RESET;
         pc_load <= 32'h0000_0000;  pc_hit <= 1'b0;  fault_hit <= 1'b0;
         o_ready <= 1'b0;  o_done <= 1'b0;  o_fault <= 1'b0;  o_branch <= 1'b0;
         o_branch_addr <= 32'h0000_0000;  o_tbit <= 1'b1;  o_flags_we <= 1'b0;
         o_mem_req <= 1'b0;  o_mem_we <= 1'b0;  o_mem_addr <= 32'h0000_0000;
         o_mem_wdata <= 32'h0000_0000;  o_mem_size <= lsu_pkg::SZ_WORD;
         o_rd_data <= 32'h0000_0000;
      end else begin
         st <= next_st;  op <= next_op;  size <= next_size;  sign <= next_sign;
         wback <= next_wback;  rt <= next_rt;  rn <= next_rn;  list <= next_list;
         wb_value <= next_wb_value;  first_addr <= next_first_addr;
         gpr <= next_gpr;  sp <= next_sp;  lr <= next_lr;
         pc_load <= next_pc_load;  pc_hit <= next_pc_hit;  fault_hit <= next_fault_hit;
         o_ready <= next_ready;  o_done <= next_done;  o_fault <= next_fault;
         o_branch <= next_branch;  o_branch_addr <= next_branch_addr;
         o_tbit <= next_tbit;
         o_flags_we <= 1'b0;
         o_mem_req <= next_mem_req;  o_mem_we <= next_mem_we;
         o_mem_addr <= next_mem_addr;  o_mem_wdata <= next_mem_wdata;
         o_mem_size <= next_mem_size;  o_rd_data <= next_rd_data;
      end
   end

   // checks on the sequencer
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   sequence s_step_ack;
      o_mem_req && i_mem_ack && is_multi && !last;
   endsequence
   sequence s_last_ack;
      o_mem_req && i_mem_ack && last;
   endsequence
   a_flags_untouched: assert property (!o_flags_we)
      else $error("condition flag write seen");
   a_word_aligned: assert property (o_mem_req && o_mem_size == lsu_pkg::SZ_WORD
      |-> o_mem_addr[1:0] == 2'b00)
      else $error("misaligned word request");
   a_half_aligned: assert property (o_mem_req && o_mem_size == lsu_pkg::SZ_HALF
      |-> !o_mem_addr[0])
      else $error("misaligned half request");
   a_fault_no_req: assert property (o_fault |-> !o_mem_req && o_done)
      else $error("fault with memory request");
   a_multi_step: assert property (s_step_ack |=> o_mem_req &&
      o_mem_addr == $past(o_mem_addr) + 32'h0000_0004)
      else $error("multiple step not four bytes");
   a_push_sp_low: assert property (s_last_ack ##0 (op == lsu_pkg::OP_PUSH)
      |=> sp == first_addr)
      else $error("push left wrong stack pointer");
   a_zero_extend: assert property (s_last_ack ##0 (is_load && !sign &&
      size == lsu_pkg::SZ_BYTE && !is_multi) |=> gpr[rt][31:8] == 24'h00_0000)
      else $error("byte load not zero extended");
   a_pop_branch: assert property (o_branch |-> o_done && !o_branch_addr[0])
      else $error("pop branch not at completion");
   a_done_ready: assert property (s_last_ack |=> ##1 o_done && o_ready)
      else $error("transfer did not complete");
endmodule : lsu_core

//--- testbench/lsu_mem_model.sv
// memory partner: byte array with optional wait states
`timescale 1ns/10ps
module lsu_mem_model (
   input  wire logic               i_clk_sys, // clock
   input  wire logic               i_slow,    // add wait states
   input  wire logic               i_req,     // request
   input  wire logic               i_we,      // store
   input  wire logic [31:0]        i_addr,    // byte address
   input  wire logic [31:0]        i_wdata,   // store data
   input  wire lsu_pkg::lsu_size_e i_size,    // width
   output logic                    o_ack,     // done pulse
   output logic [31:0]             o_rdata    // load data
);
   logic [7:0] mem [logic [31:0]];
   int         n_req = 0;
   int         dly   = 0;
   initial begin
      o_ack   = 1'b0;
      o_rdata = 32'h0000_0000;
   end
   // one beat per request; idle data toggles so stale values never match
   always @(posedge i_clk_sys) begin
      int          n;
      logic [31:0] d;
      n = (i_size == lsu_pkg::SZ_WORD) ? 4 : (i_size == lsu_pkg::SZ_HALF) ? 2 : 1;
      d = 32'h0000_0000;
      if (o_ack || !i_req) begin
         o_ack   <= 1'b0;
         o_rdata <= ~o_rdata;
         dly     <= 0;
      end else if (i_slow && dly < 3) begin
         dly <= dly + 1;
      end else begin
         for (int b = 0; b < n; b++) begin
            if (i_we) mem[i_addr + b] = i_wdata[8*b +: 8];
            else if (mem.exists(i_addr + b)) d[8*b +: 8] = mem[i_addr + b];
         end
         o_ack   <= 1'b1;
         o_rdata <= d;
         n_req   <= n_req + 1;
      end
   end
endmodule : lsu_mem_model

//--- testbench/tb.sv
// testbench for the load/store unit
`timescale 1ns/10ps
module tb;
   logic               clk = 0, srst = 1, vld = 0, sg = 0, spb = 0, wb = 0, we = 0, slow = 0;
   lsu_pkg::lsu_op_e   op = lsu_pkg::OP_ADR;
   lsu_pkg::lsu_size_e sz = lsu_pkg::SZ_WORD, msz;
   logic [2:0]         rt = 0, rn = 0, rm = 0;
   logic [9:0]         imm = 0;
   logic [8:0]         lst = 0;
   logic [3:0]         widx = 0, ridx = 0;
   logic [31:0]        pc = 0, wdat = 0, rdt, maddr, mwd, badr, rdat;
   logic               rdy, done, flt, brn, tbit, fwe, mreq, mwe, ack, f_s, b_s;
   int                 n_fail = 0, checked = 0, cyc = 0, nfw = 0;
   lsu_core u_lsu_core (.i_clk_sys(clk), .i_srst(srst), .i_cmd_valid(vld), .i_cmd_op(op),
      .i_cmd_size(sz), .i_cmd_sign(sg), .i_cmd_sp_base(spb), .i_cmd_wback(wb), .i_cmd_rt(rt),
      .i_cmd_rn(rn), .i_cmd_rm(rm), .i_cmd_imm(imm), .i_cmd_list(lst), .i_cmd_pc(pc),
      .i_wr_en(we), .i_wr_idx(widx), .i_wr_data(wdat), .i_rd_idx(ridx), .i_mem_ack(ack),
      .i_mem_rdata(rdt), .o_ready(rdy), .o_done(done), .o_fault(flt), .o_branch(brn),
      .o_branch_addr(badr), .o_tbit(tbit), .o_flags_we(fwe), .o_mem_req(mreq),
      .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_size(msz),
      .o_rd_data(rdat));
   lsu_mem_model u_mem (.i_clk_sys(clk), .i_slow(slow), .i_req(mreq), .i_we(mwe),
      .i_addr(maddr), .i_wdata(mwd), .i_size(msz), .o_ack(ack), .o_rdata(rdt));
   // clock and watchdog
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (fwe === 1'b1) nfw++;
      if (cyc > 5000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] mw(input logic [31:0] a);
      return {u_mem.mem[a+3], u_mem.mem[a+2], u_mem.mem[a+1], u_mem.mem[a]};
   endfunction : mw
   task automatic pre(input logic [3:0] i, input logic [31:0] d);
      @(posedge clk);
      we <= 1;
      widx <= i;
      wdat <= d;
      @(posedge clk);
      we <= 0;
   endtask : pre
   task automatic creg(input logic [3:0] i, input logic [31:0] e);
      @(posedge clk);
      ridx <= i;
      repeat (2) @(posedge clk);
      chk(rdat, e);
   endtask : creg
   // offer a command, hold it until taken, then wait for completion
   task automatic run(input lsu_pkg::lsu_op_e o, input lsu_pkg::lsu_size_e s,
      input logic [2:0] f, input logic [2:0] t, input logic [2:0] n, input logic [2:0] m,
      input logic [9:0] i, input logic [8:0] l);
      int k;
      @(posedge clk);
      vld <= 1;
      op <= o;
      sz <= s;
      {sg, spb, wb} <= f;
      rt <= t;
      rn <= n;
      rm <= m;
      imm <= i;
      lst <= l;
      k = 0;
      do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 40);
      vld <= 0;
      k = 0;
      do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 60);
      if (done !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED t=%0t command did not complete", $time);
      end
      f_s = flt;
      b_s = brn;
   endtask : run
   task automatic s_single;
      logic [31:0] ext [4] = '{32'h0000_C7D8, 32'hFFFF_C7D8, 32'h0000_00D8, 32'hFFFF_FFD8};
      pc <= 32'h0000_0102;
      run(lsu_pkg::OP_ADR, lsu_pkg::SZ_WORD, 3'h0, 3'h4, 3'h0, 3'h0, 10'h3FC, 9'h000);
      creg(4'h4, 32'h0000_0500);
      run(lsu_pkg::OP_ST_IMM, lsu_pkg::SZ_WORD, 3'h0, 3'h3, 3'h2, 3'h0, 10'h07C, 9'h000);
      chk(mw(32'h0000_017C), 32'hA5B6_C7D8);
      run(lsu_pkg::OP_ST_IMM, lsu_pkg::SZ_WORD, 3'h2, 3'h3, 3'h0, 3'h0, 10'h3FC, 9'h000);
      chk(mw(32'h0000_0BFC), 32'hA5B6_C7D8);
      run(lsu_pkg::OP_ST_IMM, lsu_pkg::SZ_BYTE, 3'h0, 3'h3, 3'h2, 3'h0, 10'h01F, 9'h000);
      run(lsu_pkg::OP_LD_IMM, lsu_pkg::SZ_BYTE, 3'h0, 3'h4, 3'h2, 3'h0, 10'h01F, 9'h000);
      creg(4'h4, 32'h0000_00D8);
      run(lsu_pkg::OP_ST_REG, lsu_pkg::SZ_HALF, 3'h0, 3'h3, 3'h2, 3'h6, 10'h000, 9'h000);
      for (int j = 0; j < 4; j++) begin
         run(lsu_pkg::OP_LD_REG, j[1] ? lsu_pkg::SZ_BYTE : lsu_pkg::SZ_HALF, {j[0], 2'b00},
             3'h4, 3'h2, 3'h6, 10'h000, 9'h000);
         creg(4'h4, ext[j]);
      end
      pc <= 32'h0000_0176;
      run(lsu_pkg::OP_LD_LIT, lsu_pkg::SZ_WORD, 3'h0, 3'h7, 3'h0, 3'h0, 10'h004, 9'h000);
      creg(4'h7, 32'hA5B6_C7D8);
   endtask : s_single
   task automatic s_fault;
      int k;
      k = u_mem.n_req;
      run(lsu_pkg::OP_LD_IMM, lsu_pkg::SZ_WORD, 3'h0, 3'h4, 3'h5, 3'h0, 10'h000, 9'h000);
      chk(f_s, 32'h0000_0001);
      chk(u_mem.n_req - k, 32'h0000_0000);
   endtask : s_fault
   task automatic s_multi;
      slow <= 1;
      run(lsu_pkg::OP_STM, lsu_pkg::SZ_WORD, 3'h1, 3'h0, 3'h2, 3'h0, 10'h000, 9'h009);
      chk(mw(32'h0000_0100), 32'h1111_2222);
      chk(mw(32'h0000_0104), 32'hA5B6_C7D8);
      creg(4'h2, 32'h0000_0108);
      run(lsu_pkg::OP_LDM, lsu_pkg::SZ_WORD, 3'h1, 3'h0, 3'h1, 3'h0, 10'h000, 9'h060);
      creg(4'h5, 32'h1111_2222);
      creg(4'h6, 32'hA5B6_C7D8);
      creg(4'h1, 32'h0000_0108);
      slow <= 0;
   endtask : s_multi
   task automatic s_stack;
      run(lsu_pkg::OP_PUSH, lsu_pkg::SZ_WORD, 3'h0, 3'h0, 3'h0, 3'h0, 10'h000, 9'h101);
      chk(mw(32'h0000_07F8), 32'h1111_2222);
      chk(mw(32'h0000_07FC), 32'h0000_0A01);
      creg(4'hD, 32'h0000_07F8);
      run(lsu_pkg::OP_POP, lsu_pkg::SZ_WORD, 3'h0, 3'h0, 3'h0, 3'h0, 10'h000, 9'h110);
      chk(b_s, 32'h0000_0001);
      chk(badr, 32'h0000_0A00);
      chk(tbit, 32'h0000_0001);
      creg(4'h4, 32'h1111_2222);
      creg(4'hD, 32'h0000_0800);
   endtask : s_stack
   // reset, preload, scenarios
   initial begin
      repeat (5) @(posedge clk);
      srst <= 0;
      repeat (2) @(posedge clk);
      pre(4'h0, 32'h1111_2222);
      pre(4'h1, 32'h0000_0100);
      pre(4'h2, 32'h0000_0100);
      pre(4'h3, 32'hA5B6_C7D8);
      pre(4'h5, 32'h0000_0001);
      pre(4'h6, 32'h0000_0040);
      pre(4'hD, 32'h0000_0800);
      pre(4'hE, 32'h0000_0A01);
      s_single();
      s_fault();
      s_multi();
      s_stack();
      chk(nfw, 32'h0000_0000);
      summarize();
   end
endmodule : tb
